//--- design/csel_pkg.sv
`default_nettype none
package csel_pkg;

  // ----------------------------------------------------------------
  // Strap codes and clock generation modes
  // ----------------------------------------------------------------
  localparam int STRAP_W = 3;
  localparam int FACTOR_W = 4;
  localparam int PERIOD_W = 16;

  localparam logic [STRAP_W-1:0] STRAP_X4 = 3'h7;
  localparam logic [STRAP_W-1:0] STRAP_X3 = 3'h6;
  localparam logic [STRAP_W-1:0] STRAP_X8 = 3'h5;
  localparam logic [STRAP_W-1:0] STRAP_X5 = 3'h4;
  localparam logic [STRAP_W-1:0] STRAP_DIRECT = 3'h3;
  localparam logic [STRAP_W-1:0] STRAP_X10 = 3'h2;
  localparam logic [STRAP_W-1:0] STRAP_PRESC = 3'h1;
  localparam logic [STRAP_W-1:0] STRAP_RESV = 3'h0;

  localparam logic [FACTOR_W-1:0] FACTOR_NONE = 4'h0;
  localparam logic [FACTOR_W-1:0] FACTOR_X1 = 4'h1;
  localparam logic [FACTOR_W-1:0] FACTOR_X3 = 4'h3;
  localparam logic [FACTOR_W-1:0] FACTOR_X4 = 4'h4;
  localparam logic [FACTOR_W-1:0] FACTOR_X5 = 4'h5;
  localparam logic [FACTOR_W-1:0] FACTOR_X8 = 4'h8;
  localparam logic [FACTOR_W-1:0] FACTOR_X10 = 4'ha;

  // Smoothing shift of the input period estimate.
  localparam int PERIOD_SMOOTH_SH = 2;

  typedef enum logic [2:0] {
    CSEL_MODE_RESV = 3'b000,
    CSEL_MODE_PRESC = 3'b001,
    CSEL_MODE_X10 = 3'b010,
    CSEL_MODE_DIRECT = 3'b011,
    CSEL_MODE_X5 = 3'b100,
    CSEL_MODE_X8 = 3'b101,
    CSEL_MODE_X3 = 3'b110,
    CSEL_MODE_X4 = 3'b111
  } csel_mode_t;

  // Decoded clock configuration, held from reset release onward.
  typedef struct packed {
    csel_mode_t mode;
    logic [FACTOR_W-1:0] factor;
    logic osc_amp_en;
    logic pll_en;
    logic reserved;
  } csel_cfg_t;

  // ----------------------------------------------------------------
  // Strap decoder
  // ----------------------------------------------------------------
  function automatic csel_cfg_t csel_decode(input logic [STRAP_W-1:0] s);
    csel_cfg_t c;
    c = '{mode: CSEL_MODE_RESV, factor: FACTOR_NONE, osc_amp_en: 1'b1, pll_en: 1'b0, reserved: 1'b1};
    case (s)
      STRAP_X4: c = '{mode: CSEL_MODE_X4, factor: FACTOR_X4, osc_amp_en: 1'b1, pll_en: 1'b1, reserved: 1'b0};
      STRAP_X3: c = '{mode: CSEL_MODE_X3, factor: FACTOR_X3, osc_amp_en: 1'b1, pll_en: 1'b1, reserved: 1'b0};
      STRAP_X8: c = '{mode: CSEL_MODE_X8, factor: FACTOR_X8, osc_amp_en: 1'b1, pll_en: 1'b1, reserved: 1'b0};
      STRAP_X5: c = '{mode: CSEL_MODE_X5, factor: FACTOR_X5, osc_amp_en: 1'b1, pll_en: 1'b1, reserved: 1'b0};
      STRAP_DIRECT: c = '{mode: CSEL_MODE_DIRECT, factor: FACTOR_X1, osc_amp_en: 1'b0, pll_en: 1'b0, reserved: 1'b0};
      STRAP_X10: c = '{mode: CSEL_MODE_X10, factor: FACTOR_X10, osc_amp_en: 1'b1, pll_en: 1'b1, reserved: 1'b0};
      STRAP_PRESC: c = '{mode: CSEL_MODE_PRESC, factor: FACTOR_X1, osc_amp_en: 1'b1, pll_en: 1'b0, reserved: 1'b0};
      default: c = '{mode: CSEL_MODE_RESV, factor: FACTOR_NONE, osc_amp_en: 1'b1, pll_en: 1'b0, reserved: 1'b1};
    endcase
    return c;
  endfunction

endpackage
`default_nettype wire

//--- design/csel_pll_nco.sv
`default_nettype none
// Digital stand-in for the multiplying loop: emits 2*F edge pulses per input period.
module csel_pll_nco import csel_pkg::*; #(
  parameter int PER_W = PERIOD_W,
  parameter int FAC_W = FACTOR_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic xtal_rise,
  input wire logic xtal_trans,
  input wire logic [FAC_W-1:0] factor,
  output logic edge_out,
  output logic locked
);

  logic [PER_W-1:0] per_cnt_r, per_cnt_nxt;
  logic [PER_W-1:0] per_est_r, per_est_nxt;
  logic [PER_W:0] acc_r, acc_nxt;
  logic [FAC_W-1:0] tr_cnt_r, tr_cnt_nxt;
  logic seen_r, seen_nxt;
  logic locked_r, locked_nxt;
  logic edge_r, edge_nxt;

  // ----------------------------------------------------------------
  // Period measurement, phase accumulator and resynchronisation
  // ----------------------------------------------------------------
  always_comb begin
    logic [PER_W:0] step;
    logic [PER_W:0] sum;
    step = (PER_W+1)'({factor, 1'b0});
    sum = acc_r + step;
    per_cnt_nxt = per_cnt_r;
    per_est_nxt = per_est_r;
    acc_nxt = acc_r;
    tr_cnt_nxt = tr_cnt_r;
    seen_nxt = seen_r;
    locked_nxt = locked_r;
    edge_nxt = 1'b0;
    if (!enable) begin
      per_cnt_nxt = '0;
      acc_nxt = '0;
      tr_cnt_nxt = '0;
      seen_nxt = 1'b0;
      locked_nxt = 1'b0;
    end else begin
      if (xtal_rise) begin
        per_cnt_nxt = {{(PER_W-1){1'b0}}, 1'b1};
        seen_nxt = 1'b1;
        if (seen_r && !locked_r) begin
          per_est_nxt = per_cnt_r;
          locked_nxt = 1'b1;
        end else if (locked_r) begin
          per_est_nxt = per_est_r - (per_est_r >> PERIOD_SMOOTH_SH) + (per_cnt_r >> PERIOD_SMOOTH_SH);
        end
      end else if (per_cnt_r != '1) begin
        per_cnt_nxt = per_cnt_r + 1'b1;
      end
      if (locked_r) begin
        if (sum >= {1'b0, per_est_r}) begin
          edge_nxt = 1'b1;
          acc_nxt = sum - {1'b0, per_est_r};
        end else begin
          acc_nxt = sum;
        end
      end
      if (xtal_trans) begin
        if (tr_cnt_r >= factor - 1'b1) begin
          tr_cnt_nxt = '0;
          acc_nxt = acc_nxt >> 1;
        end else begin
          tr_cnt_nxt = tr_cnt_r + 1'b1;
        end
      end
    end
  end

  // Registers of the loop model.
  always_ff @(posedge clk) begin
    if (rst) begin
      per_cnt_r <= '0;
      per_est_r <= '0;
      acc_r <= '0;
      tr_cnt_r <= '0;
      seen_r <= 1'b0;
      locked_r <= 1'b0;
      edge_r <= 1'b0;
    end else begin
      per_cnt_r <= per_cnt_nxt;
      per_est_r <= per_est_nxt;
      acc_r <= acc_nxt;
      tr_cnt_r <= tr_cnt_nxt;
      seen_r <= seen_nxt;
      locked_r <= locked_nxt;
      edge_r <= edge_nxt;
    end
  end

  assign edge_out = edge_r;
  assign locked = locked_r;

endmodule // csel_pll_nco
`default_nettype wire

//--- design/csel_top.sv
// Notes on behaviour
// - All operation paced by system clock CLK.
// - Both CPU clock edges launch actions.
// - Mode chosen from three straps during reset.
// - Decode 111..000 into factors, direct, prescale, reserved.
// - Oscillator amplifier off only in direct drive.
// - Prescaler code halves the input clock.
// - Multiplier resyncs every F transitions, smoothly.
`default_nettype none
module csel_top import csel_pkg::*; (
  input wire logic CLK,
  input wire logic RST,
  input wire logic XTAL_IN,
  input wire logic [STRAP_W-1:0] STRAP_HIGH_BYTE_BITS,
  output var csel_cfg_t CLK_CFG,
  output logic CPU_CLK,
  output logic CPU_RISE,
  output logic CPU_FALL,
  output logic CPU_EDGE,
  output logic PLL_LOCKED
);

  logic [STRAP_W-1:0] strap_r, strap_nxt;
  csel_cfg_t cfg_r, cfg_nxt;
  logic xtal_d_r, xtal_d_nxt;
  logic cpu_clk_r, cpu_clk_nxt;
  logic rise_r, rise_nxt;
  logic fall_r, fall_nxt;
  logic edge_r, edge_nxt;
  logic xtal_rise, xtal_trans, toggle, pll_run, pll_edge, pll_locked;

  // ----------------------------------------------------------------
  // Strap capture and mode decode
  // ----------------------------------------------------------------
  // Straps follow the pins while reset is held and freeze at release.
  always_comb begin
    strap_nxt = RST ? STRAP_HIGH_BYTE_BITS : strap_r;
    cfg_nxt = csel_decode(strap_nxt);
  end

  always_ff @(posedge CLK) begin
    strap_r <= strap_nxt;
    cfg_r <= cfg_nxt;
  end

  // ----------------------------------------------------------------
  // CPU clock generation
  // ----------------------------------------------------------------
  // Input pin edges, one cycle of the system clock apart.
  assign xtal_rise = XTAL_IN & ~xtal_d_r;
  assign xtal_trans = XTAL_IN ^ xtal_d_r;
  assign pll_run = cfg_r.pll_en & ~RST;

  // Multiplying loop; runs only in the multiplying codes.
  csel_pll_nco #(
    .PER_W(PERIOD_W),
    .FAC_W(FACTOR_W)
  ) u_nco (
    .clk(CLK),
    .rst(RST),
    .enable(pll_run),
    .xtal_rise(xtal_rise),
    .xtal_trans(xtal_trans),
    .factor(cfg_r.factor),
    .edge_out(pll_edge),
    .locked(pll_locked)
  );

  // Selects the source of CPU clock transitions for the latched mode.
  always_comb begin
    toggle = 1'b0;
    case (cfg_r.mode)
      CSEL_MODE_DIRECT: toggle = xtal_trans;
      CSEL_MODE_PRESC: toggle = xtal_rise;
      CSEL_MODE_X3, CSEL_MODE_X4, CSEL_MODE_X5, CSEL_MODE_X8, CSEL_MODE_X10: toggle = pll_edge;
      default: toggle = 1'b0;
    endcase
    xtal_d_nxt = XTAL_IN;
    cpu_clk_nxt = RST ? 1'b0 : (cpu_clk_r ^ toggle);
    rise_nxt = ~RST & toggle & ~cpu_clk_r;
    fall_nxt = ~RST & toggle & cpu_clk_r;
    edge_nxt = ~RST & toggle;
  end

  // Output and edge registers.
  always_ff @(posedge CLK) begin
    xtal_d_r <= xtal_d_nxt;
    cpu_clk_r <= cpu_clk_nxt;
    rise_r <= rise_nxt;
    fall_r <= fall_nxt;
    edge_r <= edge_nxt;
  end

  assign CLK_CFG = cfg_r;
  assign CPU_CLK = cpu_clk_r;
  assign CPU_RISE = rise_r;
  assign CPU_FALL = fall_r;
  assign CPU_EDGE = edge_r;
  assign PLL_LOCKED = pll_locked;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  sequence s_rst_release;
    $past(RST) ##0 !RST;
  endsequence

  property p_strap_capture;
    s_rst_release |-> (strap_r == $past(STRAP_HIGH_BYTE_BITS));
  endproperty
  a_strap_capture: assert property (p_strap_capture) else $error("Straps not caught at reset release.");

  property p_mode_hold;
    !$past(RST) |-> ($stable(cfg_r) && $stable(strap_r));
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("Clock mode changed outside reset.");

  property p_decode_x4;
    (strap_r == STRAP_X4) |-> (cfg_r.mode == CSEL_MODE_X4 && cfg_r.factor == FACTOR_X4 && cfg_r.pll_en);
  endproperty
  a_decode_x4: assert property (p_decode_x4) else $error("Code 111 not decoded as times four.");

  property p_decode_other;
    ((strap_r == STRAP_X10) |-> cfg_r.factor == FACTOR_X10) and
    ((strap_r == STRAP_X8) |-> cfg_r.factor == FACTOR_X8) and
    ((strap_r == STRAP_RESV) |-> (cfg_r.reserved && !cfg_r.pll_en));
  endproperty
  a_decode_other: assert property (p_decode_other) else $error("Strap decode mismatch.");

  property p_amp_direct;
    CLK_CFG.osc_amp_en == (strap_r != STRAP_DIRECT);
  endproperty
  a_amp_direct: assert property (p_amp_direct) else $error("Amplifier state wrong for mode.");

  property p_presc_edge;
    (cfg_r.mode == CSEL_MODE_PRESC && CPU_EDGE) |-> $past(xtal_rise);
  endproperty
  a_presc_edge: assert property (p_presc_edge) else $error("Prescaled edge without input rise.");

  property p_direct_follow;
    (cfg_r.mode == CSEL_MODE_DIRECT && xtal_trans) |=> (CPU_EDGE && CPU_CLK == $past(XTAL_IN));
  endproperty
  a_direct_follow: assert property (p_direct_follow) else $error("Direct drive did not follow input.");

  property p_edge_pair;
    CPU_RISE |-> (CPU_CLK && !$past(CPU_CLK) && !CPU_FALL);
  endproperty
  a_edge_pair: assert property (p_edge_pair) else $error("Rise strobe not at a rising edge.");

  property p_fall_edge;
    CPU_FALL |-> (!CPU_CLK && $past(CPU_CLK, 1));
  endproperty
  a_fall_edge: assert property (p_fall_edge) else $error("Fall strobe not at a falling edge.");

  property p_pll_source;
    (cfg_r.pll_en && CPU_EDGE) |-> $past(pll_edge);
  endproperty
  a_pll_source: assert property (p_pll_source) else $error("Multiplied edge not from loop.");

  property p_reserved_quiet;
    cfg_r.reserved |-> !CPU_EDGE;
  endproperty
  a_reserved_quiet: assert property (p_reserved_quiet) else $error("Reserved code produced a clock.");

  property p_rst_track;
    disable iff (1'b0) RST |=> (strap_r == $past(STRAP_HIGH_BYTE_BITS));
  endproperty
  a_rst_track: assert property (p_rst_track) else $error("Straps did not follow the pins in reset.");

  property p_rst_quiet;
    disable iff (1'b0) RST |=> (!CPU_CLK && !CPU_EDGE && !CPU_RISE && !CPU_FALL && !PLL_LOCKED);
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("Clock outputs active during reset.");

  // A sampled input rise while the prescaler code is latched.
  sequence s_presc_rise;
    cfg_r.mode == CSEL_MODE_PRESC && xtal_rise;
  endsequence

  // A CPU clock transition together with its edge strobe.
  sequence s_cpu_toggle;
    CPU_EDGE && (CPU_CLK != $past(CPU_CLK));
  endsequence

  property p_presc_walk;
    s_presc_rise |=> s_cpu_toggle;
  endproperty
  a_presc_walk: assert property (p_presc_walk) else $error("Prescaler missed an input rise.");

  property p_presc_quiet;
    (cfg_r.mode == CSEL_MODE_PRESC && !xtal_rise) |=> !CPU_EDGE;
  endproperty
  a_presc_quiet: assert property (p_presc_quiet) else $error("Prescaler toggled without input rise.");

  property p_direct_quiet;
    (cfg_r.mode == CSEL_MODE_DIRECT && !xtal_trans) |=> !CPU_EDGE;
  endproperty
  a_direct_quiet: assert property (p_direct_quiet) else $error("Direct drive edge without input edge.");

  property p_edge_toggle;
    CPU_EDGE |-> s_cpu_toggle;
  endproperty
  a_edge_toggle: assert property (p_edge_toggle) else $error("Edge strobe without clock transition.");

  property p_clk_hold;
    !CPU_EDGE |-> $stable(CPU_CLK);
  endproperty
  a_clk_hold: assert property (p_clk_hold) else $error("Clock moved without an edge strobe.");

  // Multiplied mode still waiting for its first period estimate.
  sequence s_pll_waiting;
    cfg_r.pll_en && !PLL_LOCKED;
  endsequence

  property p_pll_wait_quiet;
    s_pll_waiting |=> !CPU_EDGE;
  endproperty
  a_pll_wait_quiet: assert property (p_pll_wait_quiet) else $error("Multiplied edge before lock.");

  property p_lock_stays;
    (cfg_r.pll_en && PLL_LOCKED) |=> PLL_LOCKED;
  endproperty
  a_lock_stays: assert property (p_lock_stays) else $error("Loop lost lock while running.");

endmodule // csel_top
`default_nettype wire

//--- tb/csel_xtal_model.sv
`default_nettype none
// Oscillator model: a square wave of half period half CLK cycles, still at 0 while run is low.
module csel_xtal_model (
  input wire logic clk,
  input wire logic run,
  input wire logic [7:0] half,
  output logic xtal
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] cnt;
  initial begin
    xtal = 1'b0;
    cnt = 8'h00;
  end
  // crystal-like source
  // The same free oscillation feeds every mode; it is never a forced edge pattern.
  always @(posedge clk) begin
    if (!run) begin
      xtal <= 1'b0;
      cnt <= 8'h00;
    end else if (cnt == half - 8'h01) begin
      xtal <= ~xtal;
      cnt <= 8'h00;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end
endmodule // csel_xtal_model
`default_nettype wire

//--- tb/csel_top_tb.sv
`default_nettype none
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin bad_count++; \
  $display("mismatch %s expected %0h seen %0h", nm, ex, got); end end
module csel_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import csel_pkg::*;
  logic clk, rst, run, xin, cpu_clk, cpu_rise, cpu_fall, cpu_edge, locked;
  logic [STRAP_W-1:0] straps;
  logic [7:0] half;
  csel_cfg_t cfg;
  int bad_count = 0;
  int compares = 0;
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  csel_xtal_model u_xtal (.clk(clk), .run(run), .half(half), .xtal(xin));
  csel_top u_dut (.CLK(clk), .RST(rst), .XTAL_IN(xin), .STRAP_HIGH_BYTE_BITS(straps), .CLK_CFG(cfg),
    .CPU_CLK(cpu_clk), .CPU_RISE(cpu_rise), .CPU_FALL(cpu_fall), .CPU_EDGE(cpu_edge), .PLL_LOCKED(locked));
  // Multiplication factor that each strap code should select.
  function automatic int f_of(input logic [2:0] c);
    int t[8] = '{0, 1, 10, 1, 5, 8, 3, 4};
    return t[c];
  endfunction
  task automatic do_reset(input logic [2:0] c);
    @(posedge clk);
    #1 rst = 1'b1;
    run = 1'b0;
    straps = c;
    repeat (6) @(posedge clk);
    #1 rst = 1'b0;
    run = 1'b1;
  endtask
  // Counts CPU pulses and input transitions over n cycles, checking edge pairing each cycle.
  task automatic count(input int n, output int r, output int f, output int e, output int xr, output int xt);
    logic px;
    r = 0; f = 0; e = 0; xr = 0; xt = 0;
    px = xin;
    repeat (n) begin
      @(posedge clk);
      #1;
      `CHK("edge_pair", cpu_rise | cpu_fall, cpu_edge)
      `CHK("rise_fall_apart", 1'b0, cpu_rise & cpu_fall)
      r += int'(cpu_rise === 1'b1);
      f += int'(cpu_fall === 1'b1);
      e += int'(cpu_edge === 1'b1);
      if (xin !== px) begin
        xt++;
        xr += int'(xin === 1'b1);
      end
      px = xin;
    end
  endtask
  // Every code decodes to its mode and is held against later strap changes.
  task automatic t_decode;
    logic [9:0] ex;
    for (int c = 0; c < 8; c++) begin
      do_reset(c[2:0]);
      ex = {c[2:0], 4'(f_of(c[2:0])), c != 3, c != 0 && c != 1 && c != 3, c == 0};
      `CHK("cfg", ex, cfg)
      straps = ~c[2:0];
      repeat (5) @(posedge clk) #1;
      `CHK("cfg_held", ex, cfg)
    end
  endtask
  // Direct drive and prescaler follow the input at x1 and /2.
  task automatic t_direct_presc;
    int r, f, e, xr, xt;
    half = 8'h05;
    do_reset(STRAP_DIRECT);
    count(20, r, f, e, xr, xt);
    count(200, r, f, e, xr, xt);
    `CHK("direct_edges", 1'b1, e >= xt - 1 && e <= xt + 1)
    `CHK("direct_alt", 1'b1, r - f <= 1 && f - r <= 1)
    do_reset(STRAP_PRESC);
    count(20, r, f, e, xr, xt);
    count(200, r, f, e, xr, xt);
    `CHK("presc_edges", 1'b1, e >= xr - 1 && e <= xr + 1)
    `CHK("presc_rises", 1'b1, 2 * r >= xr - 2 && 2 * r <= xr + 2)
  endtask
  // Multiplying codes give 2F CPU edges per input period once locked.
  task automatic t_mult;
    logic [2:0] codes[5] = '{STRAP_X4, STRAP_X3, STRAP_X8, STRAP_X5, STRAP_X10};
    int r, f, e, xr, xt, k;
    half = 8'h10;
    foreach (codes[i]) begin
      k = 2 * f_of(codes[i]);
      do_reset(codes[i]);
      count(640, r, f, e, xr, xt);
      `CHK("locked", 1'b1, locked)
      count(256, r, f, e, xr, xt);
      `CHK("mult_edges", 1'b1, e >= k * xr - k && e <= k * xr + k)
      `CHK("mult_alt", 1'b1, r - f <= 1 && f - r <= 1)
    end
  endtask
  // The reserved code leaves the CPU clock stopped.
  task automatic t_reserved;
    int r, f, e, xr, xt;
    half = 8'h05;
    do_reset(STRAP_RESV);
    count(100, r, f, e, xr, xt);
    `CHK("resv_edges", 0, e)
    `CHK("resv_clk", 1'b0, cpu_clk)
  endtask
  task automatic conclude;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    run = 1'b0;
    straps = STRAP_X4;
    half = 8'h05;
    t_decode();
    t_direct_presc();
    t_mult();
    t_reserved();
    conclude();
  end
  // Watchdog well past the expected run of some 5200 cycles.
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    conclude();
  end
endmodule // csel_top_tb
`default_nettype wire
